// file: logic/aslp_pkg.sv
// Purpose: Constants and carriers for the sample lane packer
// Assumes: Samples of N bits sit in the low N bits of a 12-bit slot
// Notes: Mode codes, lane masks and frame carriers
// Operation
// (RULE1) Mode 4: three lanes, A0 B0 C0 D0 packed across 16-bit lanes.
// (RULE2) Mode 5: lane 0 holds A0 then B0, lane 1 C0 then D0.
// (RULE3) Mode 6: six lanes, two samples per channel split across lane triples.
// (RULE4) Mode 7: one octet per lane, lanes 0-3 carry A0 B0 C0 D0.
// (RULE5) Mode 8: each lane carries two 12-bit samples of one channel.
// (RULE6) Mode 9: eight lanes carry A0 A1 B0 B1 C0 C1 D0 D1.
// (RULE7) Mode 10: four 10-bit samples per lane, even and odd split.
// (RULE8) Mode 11: lane k carries A or B samples k..k+16 step 4, then tail.
// (RULE9) Every leftover tail bit is sent as zero.
// (RULE10) Samples are placed most significant bit first.
// (RULE11) One mapping per frame by mode, repeated frame after frame.
package aslp_pkg;
	localparam int unsigned SMP_W = 12;
	localparam int unsigned N_CH = 4;
	localparam int unsigned N_SMP = 20;
	localparam int unsigned N_LANE = 8;
	localparam int unsigned LANE_W = 64;
	localparam logic [3:0] MODE4 = 4'h4;
	localparam logic [3:0] MODE5 = 4'h5;
	localparam logic [3:0] MODE6 = 4'h6;
	localparam logic [3:0] MODE7 = 4'h7;
	localparam logic [3:0] MODE8 = 4'h8;
	localparam logic [3:0] MODE9 = 4'h9;
	localparam logic [3:0] MODE10 = 4'ha;
	localparam logic [3:0] MODE11 = 4'hb;
	localparam logic [3:0] OCT_M4 = 4'h2;
	localparam logic [3:0] OCT_M5 = 4'h2;
	localparam logic [3:0] OCT_M6 = 4'h2;
	localparam logic [3:0] OCT_M7 = 4'h1;
	localparam logic [3:0] OCT_M8 = 4'h3;
	localparam logic [3:0] OCT_M9 = 4'h1;
	localparam logic [3:0] OCT_M10 = 4'h5;
	localparam logic [3:0] OCT_M11 = 4'h8;
	localparam logic [7:0] LMASK_M4 = 8'h07;
	localparam logic [7:0] LMASK_M5 = 8'h03;
	localparam logic [7:0] LMASK_M6 = 8'h3f;
	localparam logic [7:0] LMASK_M7 = 8'h0f;
	localparam logic [7:0] LMASK_M8 = 8'h0f;
	localparam logic [7:0] LMASK_M9 = 8'hff;
	localparam logic [7:0] LMASK_M10 = 8'hff;
	localparam logic [7:0] LMASK_M11 = 8'hff;
	localparam logic RST_VALID = 1'b0;
	localparam logic RST_READY = 1'b0;
	typedef logic [SMP_W-1:0] aslp_smp_t;
	typedef struct packed {
		aslp_smp_t [N_CH-1:0][N_SMP-1:0] smp;
	} aslp_in_s;
	typedef struct packed {
		logic [N_LANE-1:0][LANE_W-1:0] lane;
		logic [N_LANE-1:0] lane_en;
		logic [3:0] octets;
		logic [3:0] mode;
	} aslp_frame_s;
endpackage

// file: logic/aslp_packer.sv
// Purpose: Map converter samples onto serial lane octets per frame
// Assumes: Channel index 0..3 is A..D; lane data left-justified
// Notes: Two-entry skid buffer between packer and link layer
`timescale 1ns/1ps
`default_nettype none
module aslp_packer (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic [3:0] transport_format_select,
	input wire logic link_data_en,
	input wire logic in_valid,
	output logic in_ready,
	input wire aslp_pkg::aslp_in_s in_frame,
	output logic out_valid,
	input wire logic out_ready,
	output aslp_pkg::aslp_frame_s out_frame
);
	// ****************************************
	// Packing
	// ****************************************
	function automatic aslp_pkg::aslp_frame_s pack_f(input logic [3:0] m,
		input aslp_pkg::aslp_in_s s);
		aslp_pkg::aslp_frame_s f;
		f = '0;
		f.mode = m;
		case (m)
			aslp_pkg::MODE4: begin
				f.lane[0][63-:16] = {s.smp[0][0], s.smp[1][0][11:8]}; // RULE1
				f.lane[1][63-:16] = {s.smp[1][0][7:0], s.smp[2][0][11:4]}; // RULE1
				f.lane[2][63-:16] = {s.smp[2][0][3:0], s.smp[3][0]}; // RULE1
				f.lane_en = aslp_pkg::LMASK_M4;
				f.octets = aslp_pkg::OCT_M4;
			end
			aslp_pkg::MODE5: begin
				f.lane[0][63-:16] = {s.smp[0][0][7:0], s.smp[1][0][7:0]}; // RULE2
				f.lane[1][63-:16] = {s.smp[2][0][7:0], s.smp[3][0][7:0]}; // RULE2
				f.lane_en = aslp_pkg::LMASK_M5;
				f.octets = aslp_pkg::OCT_M5;
			end
			aslp_pkg::MODE6: begin
				for (int c = 0; c < 2; c++) begin
					f.lane[3*c][63-:16] = {s.smp[2*c][0], s.smp[2*c][1][11:8]}; // RULE3
					f.lane[3*c+1][63-:16] = {s.smp[2*c][1][7:0],
						s.smp[2*c+1][0][11:4]}; // RULE3
					f.lane[3*c+2][63-:16] = {s.smp[2*c+1][0][3:0],
						s.smp[2*c+1][1]}; // RULE3
				end
				f.lane_en = aslp_pkg::LMASK_M6;
				f.octets = aslp_pkg::OCT_M6;
			end
			aslp_pkg::MODE7: begin
				for (int c = 0; c < 4; c++) begin
					f.lane[c][63-:8] = s.smp[c][0][7:0]; // RULE4
				end
				f.lane_en = aslp_pkg::LMASK_M7;
				f.octets = aslp_pkg::OCT_M7;
			end
			aslp_pkg::MODE8: begin
				for (int c = 0; c < 4; c++) begin
					f.lane[c][63-:24] = {s.smp[c][0], s.smp[c][1]}; // RULE5
				end
				f.lane_en = aslp_pkg::LMASK_M8;
				f.octets = aslp_pkg::OCT_M8;
			end
			aslp_pkg::MODE9: begin
				for (int c = 0; c < 4; c++) begin
					for (int p = 0; p < 2; p++) begin
						f.lane[2*c+p][63-:8] = s.smp[c][p][7:0]; // RULE6
					end
				end
				f.lane_en = aslp_pkg::LMASK_M9;
				f.octets = aslp_pkg::OCT_M9;
			end
			aslp_pkg::MODE10: begin
				for (int c = 0; c < 4; c++) begin
					for (int p = 0; p < 2; p++) begin
						for (int k = 0; k < 4; k++) begin
							f.lane[2*c+p][63-10*k-:10] = s.smp[c][p+2*k][9:0]; // RULE7
						end
					end
				end
				f.lane_en = aslp_pkg::LMASK_M10;
				f.octets = aslp_pkg::OCT_M10;
			end
			aslp_pkg::MODE11: begin
				// Low four bits of each lane stay zero as tail
				for (int c = 0; c < 2; c++) begin
					for (int k = 0; k < 4; k++) begin
						for (int j = 0; j < 5; j++) begin
							f.lane[4*c+k][63-12*j-:12] = s.smp[c][k+4*j]; // RULE8
						end
					end
				end
				f.lane_en = aslp_pkg::LMASK_M11;
				f.octets = aslp_pkg::OCT_M11;
			end
			default: begin
				// Unsupported mode: empty frame, no lanes enabled
				f.lane_en = '0;
				f.octets = '0;
			end
		endcase
		return f;
	endfunction

	aslp_pkg::aslp_frame_s pack_w;
	logic accept;
	assign pack_w = pack_f(transport_format_select, in_frame); // RULE10 RULE9
	assign accept = in_valid && in_ready && link_data_en; // RULE11

	// ****************************************
	// Skid buffer
	// ****************************************
	aslp_pkg::aslp_frame_s skid_q;
	logic skid_v_q;
	logic skid_v_d;

	always_comb begin
		skid_v_d = skid_v_q;
		if (out_ready) begin
			skid_v_d = 1'b0;
		end else if (accept && out_valid) begin
			skid_v_d = 1'b1;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			skid_v_q <= aslp_pkg::RST_VALID;
			skid_q <= '0;
		end else begin
			skid_v_q <= skid_v_d;
			if (accept && out_valid && !out_ready) begin
				skid_q <= pack_w;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			out_valid <= aslp_pkg::RST_VALID;
			out_frame <= '0;
		end else if (!out_valid || out_ready) begin
			if (skid_v_q) begin
				out_valid <= 1'b1;
				out_frame <= skid_q;
			end else if (accept) begin
				out_valid <= 1'b1;
				out_frame <= pack_w; // RULE11
			end else begin
				out_valid <= 1'b0;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			in_ready <= aslp_pkg::RST_READY;
		end else begin
			in_ready <= link_data_en && !skid_v_d;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);

	mode4_map_a: assert property (accept && // RULE1
		transport_format_select == aslp_pkg::MODE4 |->
		pack_w.lane[1][63:48] == {in_frame.smp[1][0][7:0], in_frame.smp[2][0][11:4]}
		&& pack_w.lane[2][51:48] == in_frame.smp[3][0][3:0])
		else $error("mode 4 lane map wrong");
	mode5_map_a: assert property (accept && // RULE2
		transport_format_select == aslp_pkg::MODE5 |->
		pack_w.lane[1][55:48] == in_frame.smp[3][0][7:0] && pack_w.lane_en == 8'h03)
		else $error("mode 5 lane map wrong");
	mode6_map_a: assert property (accept && // RULE3
		transport_format_select == aslp_pkg::MODE6 |->
		pack_w.lane[5][63:60] == in_frame.smp[3][0][3:0]
		&& pack_w.lane[4][55:48] == in_frame.smp[3][0][11:4])
		else $error("mode 6 lane map wrong");
	mode7_map_a: assert property (accept && // RULE4
		transport_format_select == aslp_pkg::MODE7 |->
		pack_w.lane[3][63:56] == in_frame.smp[3][0][7:0] && pack_w.lane[3][55:0] == '0)
		else $error("mode 7 lane map wrong");
	mode8_map_a: assert property (accept && // RULE5
		transport_format_select == aslp_pkg::MODE8 |->
		pack_w.lane[2][51:40] == in_frame.smp[2][1] && pack_w.octets == 4'h3)
		else $error("mode 8 lane map wrong");
	mode9_map_a: assert property (accept && // RULE6
		transport_format_select == aslp_pkg::MODE9 |->
		pack_w.lane[5][63:56] == in_frame.smp[2][1][7:0])
		else $error("mode 9 lane map wrong");
	mode10_map_a: assert property (accept && // RULE7
		transport_format_select == aslp_pkg::MODE10 |->
		pack_w.lane[7][33:24] == in_frame.smp[3][7][9:0])
		else $error("mode 10 lane map wrong");
	mode11_map_a: assert property (accept && // RULE8
		transport_format_select == aslp_pkg::MODE11 |->
		pack_w.lane[6][15:4] == in_frame.smp[1][18])
		else $error("mode 11 lane map wrong");
	tail_zero_a: assert property (out_valid && out_frame.mode == aslp_pkg::MODE11 |-> // RULE9
		out_frame.lane[0][3:0] == '0 && out_frame.lane[7][3:0] == '0)
		else $error("tail bits not zero");
	msb_first_a: assert property (accept && // RULE10
		transport_format_select == aslp_pkg::MODE8 |->
		pack_w.lane[0][63] == in_frame.smp[0][0][11])
		else $error("sample not msb first");
	hold_out_a: assert property (out_valid && !out_ready |=> // RULE11
		out_valid && $stable(out_frame))
		else $error("output changed under stall");
	flow_out_a: assert property (accept |=> out_valid) // RULE11
		else $error("accepted frame not presented");
	empty_mode_a: assert property (accept && // RULE11
		(transport_format_select < aslp_pkg::MODE4 || transport_format_select > aslp_pkg::MODE11)
		|-> pack_w.lane == '0 && pack_w.lane_en == '0 && pack_w.octets == '0)
		else $error("unsupported mode not empty");
	ready_gate_a: assert property (!link_data_en |=> !in_ready) // RULE11
		else $error("ready without link");
	skid_order_a: assert property (skid_v_q && out_ready |=> // RULE11
		out_valid && out_frame == $past(skid_q))
		else $error("buffered frame lost or reordered");

	stall_fill_c: cover property (accept && out_valid && !out_ready ##1 !in_ready);
	gate_c: cover property (in_valid && !link_data_en);
	mode11_frame_c: cover property (out_valid && out_ready
		&& out_frame.mode == aslp_pkg::MODE11);
	stream_c: cover property ((accept && out_ready)[*4]);
endmodule
`default_nettype wire

// file: dv/aslp_sink_model.sv
// Purpose: Link-side sink that takes framed lanes from the packer
// Assumes: Ready is registered; under stall only one cycle in four is ready
// Notes: Taken frames are queued in order for the bench to judge
`timescale 1ns/1ps
`default_nettype none
module aslp_sink_model (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic stall,
	input wire logic out_valid,
	input wire aslp_pkg::aslp_frame_s out_frame,
	output logic out_ready
);
	aslp_pkg::aslp_frame_s got[$];
	logic [1:0] cnt_q;
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			out_ready <= 1'b0;
			cnt_q <= 2'h0;
		end else begin
			if (out_valid && out_ready) begin
				got.push_back(out_frame);
			end
			cnt_q <= cnt_q + 2'h1;
			out_ready <= !stall || cnt_q == 2'h3;
		end
	end
endmodule
`default_nettype wire

// file: dv/tb.sv
// Purpose: Self-checking bench for the sample lane packer
// Assumes: Sink model stands on the link side
// Notes: Unsupported modes expect an empty frame
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic core_clk = 0, rst_b = 0, lde = 0, vld = 0, stall = 0;
	logic [3:0] mode = 4'h0;
	logic rdy, ov, ordy;
	aslp_pkg::aslp_in_s din = '0;
	aslp_pkg::aslp_frame_s ofr, exq[$];
	int n_mismatch = 0, checks = 0;
	int wt[4:11] = '{12, 8, 12, 8, 12, 8, 10, 12};
	int lw[4:11] = '{16, 16, 16, 8, 24, 8, 40, 60};
	int nl[4:11] = '{3, 2, 6, 4, 4, 8, 8, 8};
	always #2.5 core_clk = ~core_clk;
	aslp_packer i_dut (.core_clk(core_clk), .rst_b(rst_b), .transport_format_select(mode),
		.link_data_en(lde), .in_valid(vld), .in_ready(rdy), .in_frame(din),
		.out_valid(ov), .out_ready(ordy), .out_frame(ofr));
	aslp_sink_model i_sink (.core_clk(core_clk), .rst_b(rst_b), .stall(stall),
		.out_valid(ov), .out_frame(ofr), .out_ready(ordy));
	// ****************************************
	// Reference mapping and tasks
	// ****************************************
	function automatic aslp_pkg::aslp_in_s mk(int f);
		aslp_pkg::aslp_in_s s;
		for (int c = 0; c < 4; c++) begin
			for (int n = 0; n < 20; n++) begin
				s.smp[c][n] = 12'(f * 97 + c * 331 + n * 53 + 1);
			end
		end
		return s;
	endfunction
	function automatic aslp_pkg::aslp_frame_s exp_frame(int m, int f);
		aslp_pkg::aslp_frame_s r;
		aslp_pkg::aslp_in_s s;
		int q, p, ch, n;
		s = mk(f);
		r = '0;
		r.mode = 4'(m);
		if (m < 4 || m > 11) return r;
		r.octets = 4'((lw[m] + 7) / 8);
		for (int l = 0; l < nl[m]; l++) begin
			r.lane_en[l] = 1'b1;
			for (int b = 0; b < lw[m]; b++) begin
				q = l * lw[m] + b;
				p = q / wt[m];
				if (m < 8 && m != 6) begin
					ch = p;
					n = 0;
				end else if (m < 10) begin
					ch = p / 2;
					n = p % 2;
				end else if (m == 10) begin
					ch = p / 8;
					n = 2 * (p % 4) + (p / 4) % 2;
				end else begin
					ch = p / 20;
					n = (p / 5) % 4 + 4 * (p % 5);
				end
				r.lane[l][63-b] = s.smp[ch][n][wt[m]-1-q%wt[m]];
			end
		end
		return r;
	endfunction
	task automatic err(string s);
		n_mismatch++;
		$display("Error at %0t: %s", $time, s);
	endtask
	task automatic send(int m, int f);
		@(posedge core_clk) #1;
		mode = 4'(m);
		din = mk(f);
		vld = 1'b1;
		exq.push_back(exp_frame(m, f));
		while (rdy !== 1'b1) @(posedge core_clk) #1;
		@(posedge core_clk) #1;
		vld = 1'b0;
	endtask
	task automatic check_all(string name);
		repeat (40) @(posedge core_clk);
		#1;
		checks++;
		if (i_sink.got.size() != exq.size()) err("frame count");
		else for (int i = 0; i < exq.size(); i++) begin
			checks++;
			if (i_sink.got[i] !== exq[i]) err("frame content");
		end
		i_sink.got.delete();
		exq.delete();
		$display("Test %s done", name);
	endtask
	task automatic t_gate();
		@(posedge core_clk) #1;
		lde = 1'b0;
		vld = 1'b1;
		repeat (6) @(posedge core_clk);
		#1;
		checks++;
		if (rdy !== 1'b0 || ov !== 1'b0 || i_sink.got.size() != 0) err("taken without link");
		vld = 1'b0;
		lde = 1'b1;
		$display("Test gate done");
	endtask
	task automatic t_modes();
		for (int k = 2; k < 13; k++) begin
			send(k, 2 * k);
			send(k, 2 * k + 1);
		end
		check_all("modes");
	endtask
	task automatic t_stall();
		stall = 1'b1;
		for (int k = 0; k < 6; k++) send(6 + k % 3, 40 + k);
		check_all("stall");
		stall = 1'b0;
	endtask
	task automatic t_reset();
		stall = 1'b1;
		send(8, 60);
		send(6, 61);
		@(posedge core_clk) #1;
		rst_b = 1'b0;
		stall = 1'b0;
		#1;
		checks++;
		if (ov !== 1'b0 || rdy !== 1'b0) err("reset mid-run");
		repeat (2) @(posedge core_clk);
		#1;
		rst_b = 1'b1;
		i_sink.got.delete();
		exq.delete();
		@(posedge core_clk) #1;
		checks++;
		if (rdy !== 1'b1 || ov !== 1'b0) err("not ready after reset");
		send(5, 62);
		check_all("reset");
	endtask
	task automatic wrap_up();
		$display("Comparisons %0d, mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	initial begin
		#20000;
		err("watchdog expired");
		wrap_up();
	end
	initial begin
		repeat (16) @(posedge core_clk);
		#1;
		rst_b = 1'b1;
		lde = 1'b1;
		checks++;
		if (ov !== 1'b0 || rdy !== 1'b0) err("reset state");
		t_modes();
		t_stall();
		t_reset();
		t_gate();
		wrap_up();
	end
endmodule
`default_nettype wire
